// file: bench/pcd_checker.sv
// concurrent checks on the port block pins
`timescale 1ns/1ps
`default_nettype none
module pcd_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [pcd_pkg::PCD_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcd_pkg::PCD_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // first port, transmitter and stop recovery
    input wire logic [7:0] first_port_in,
    input wire logic [7:0] first_port_out,
    input wire logic [7:0] first_port_oe,
    input wire logic uart_tx_enable,
    input wire logic uart_txd,
    input wire logic stop_recovery
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_misaligned_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    chk_config_reads: assert property (
        pready && !pwrite && paddr == 16'h3c00 |-> prdata[7:0] == 8'hff)
        else $error("configuration read not all ones");
    chk_nibble_reads: assert property (
        pready && !pwrite && paddr == 16'h03e0 |-> prdata[7:0] == 8'hff)
        else $error("nibble direction read not all ones");
    chk_pin_read: assert property (
        ($stable(first_port_in) [*4] ##0 (pready && !pwrite && paddr == 16'h0000))
        |-> prdata[7:0] == first_port_in)
        else $error("pin read differs from pins");
    chk_stop_input: assert property (stop_recovery |-> ##2 first_port_oe == 8'h00)
        else $error("stop recovery left pins driven");
    chk_tx_override: assert property (
        $past(uart_tx_enable) |-> first_port_out[7] == $past(uart_txd))
        else $error("transmit data missing on top pin");
    cover property (pready && pslverr);
    cover property (stop_recovery);
    cover property (pready && !pwrite && paddr == 16'h0000);
endmodule : pcd_checker
`default_nettype wire

// file: bench/pcd_pin_model.sv
// far side of one port: pull-up resistors and an outside driver
`timescale 1ns/1ps
`default_nettype none
module pcd_pin_model (
    // design drive
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // outside drive
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // resolved levels
    output logic [7:0] level
);
    // released lines float high through the pull-up option
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule : pcd_pin_model
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the port configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, err;
    logic [7:0] p1_out, p1_oe, p1_lvl, p2_out, p2_oe, p2_lvl, rd;
    logic [7:0] x1_v = 8'h00, x1_en = 8'h00, x2_v = 8'h00, x2_en = 8'h00;
    logic [3:0] p3_out;
    logic tx_en = 1'b0, txd = 1'b0, c1 = 1'b0, c2 = 1'b0, ir = 1'b0, stop = 1'b0;
    int bad_count = 0;
    int n_compared = 0;
    int d, v, x, oe;
    always #25 pclk = ~pclk;
    pcd_port_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_port_in(p1_lvl), .first_port_out(p1_out),
        .first_port_oe(p1_oe), .second_port_in(p2_lvl), .second_port_out(p2_out),
        .second_port_oe(p2_oe), .third_port_out(p3_out), .uart_tx_enable(tx_en),
        .uart_txd(txd), .comparator_1_result(c1), .comparator_2_result(c2),
        .ir_amp_result(ir), .stop_recovery(stop));
    pcd_pin_model pins1 (.pin_out(p1_out), .pin_oe(p1_oe), .ext_val(x1_v), .ext_en(x1_en),
        .level(p1_lvl));
    pcd_pin_model pins2 (.pin_out(p2_out), .pin_oe(p2_oe), .ext_val(x2_v), .ext_en(x2_en),
        .level(p2_lvl));
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one idle edge after each transfer keeps drives one per time step
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        paddr <= {2'b00, idx, 2'b00};
        pwrite <= w;
        pwdata <= {24'h00_0000, wd};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 16) begin
            bad_count++;
            finish_test();
        end
    endtask : apb
    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask : rd_chk
    // output register plus two synchroniser stages
    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf0fa));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(PCD_IDX_PORT_OUTPUT_CONFIGURATION, 8'hff);
        rd_chk(PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION, 8'hff);
        rd_chk(PCD_IDX_SECOND_PORT_DIRECTION, 8'hff);
        chk(p1_oe | p2_oe, 0);
        apb(1'b0, 12'h001, 8'h00);
        chk({err, rd}, 9'h100);
        $display("reset test done");
        d = $urandom_range(255);
        v = $urandom_range(255);
        x = $urandom_range(255);
        x2_v <= x[7:0];
        x2_en <= d[7:0];
        apb(1'b1, PCD_IDX_SECOND_PORT_DIRECTION, d[7:0]);
        rd_chk(PCD_IDX_SECOND_PORT_DIRECTION, d[7:0]);
        apb(1'b1, PCD_IDX_SECOND_PORT_DATA, v[7:0]);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, PCD_IDX_THIRD_PORT_MODE, m[7:0]);
            settle();
            chk(p2_oe, ~d & (m == 1 ? 255 : ~v) & 255);
            rd_chk(PCD_IDX_SECOND_PORT_DATA, (d & x) | (~d & v));
        end
        $display("second port test done");
        apb(1'b1, PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION, 8'h00);
        apb(1'b1, PCD_IDX_PORT_OUTPUT_CONFIGURATION, 8'h00);
        apb(1'b1, PCD_IDX_FIRST_PORT_DATA, v[7:0]);
        settle();
        chk(p1_out, v);
        chk(p1_oe, ~v & 255);
        rd_chk(PCD_IDX_FIRST_PORT_DATA, v[7:0]);
        rd_chk(PCD_IDX_PORT_OUTPUT_CONFIGURATION, 8'hff);
        rd_chk(PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION, 8'hff);
        apb(1'b1, PCD_IDX_PORT_OUTPUT_CONFIGURATION, 8'h04);
        for (int n = 0; n < 4; n++) begin
            oe = (n[1] ? 0 : 8'hf0) | (n[0] ? 0 : 8'h0f);
            x = $urandom_range(255);
            x1_v <= x[7:0];
            x1_en <= ~oe[7:0];
            apb(1'b1, PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION, {1'b0, n[1], 5'h00, n[0]});
            settle();
            chk(p1_oe, oe);
            rd_chk(PCD_IDX_FIRST_PORT_DATA, (v & oe) | (x & ~oe));
        end
        $display("first port test done");
        apb(1'b1, PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION, 8'h00);
        tx_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            txd <= i[0];
            repeat (3) @(posedge pclk);
            chk({p1_oe[7], p1_out[7]}, {1'b1, i[0]});
        end
        txd <= v[7];
        apb(1'b1, PCD_IDX_FIRST_PORT_DATA, ~v[7:0]);
        settle();
        chk(p1_out, {v[7], ~v[6:0]});
        apb(1'b1, PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION, 8'h40);
        settle();
        chk(p1_oe[7], 1'b0);
        tx_en <= 1'b0;
        apb(1'b1, PCD_IDX_FIRST_PORT_DATA, v[7:0]);
        $display("transmitter test done");
        apb(1'b1, PCD_IDX_THIRD_PORT_DATA, 8'h90);
        settle();
        chk(p3_out, 4'h9);
        rd_chk(PCD_IDX_THIRD_PORT_DATA, 8'h90);
        rd_chk(PCD_IDX_THIRD_PORT_MODE, 8'hff);
        apb(1'b1, PCD_IDX_PORT_OUTPUT_CONFIGURATION, 8'h05);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, PCD_IDX_THIRD_PORT_MODE, {5'h00, m[0], 2'b01});
            for (int k = 0; k < 8; k++) begin
                {ir, c2, c1} <= k[2:0];
                settle();
                chk({p3_out[3], p3_out[0]}, {k[1], (m == 1 ? k[2] : k[0])});
            end
        end
        $display("comparator test done");
        apb(1'b1, PCD_IDX_PORT_OUTPUT_CONFIGURATION, 8'h00);
        stop <= 1'b1;
        @(posedge pclk);
        stop <= 1'b0;
        settle();
        chk(p1_oe, 8'h00);
        chk(p2_oe, ~d & 255);
        apb(1'b1, PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION, 8'h00);
        settle();
        chk(p1_oe, ~v & 255);
        $display("stop recovery test done");
        finish_test();
    end
endmodule : tb
bind pcd_port_ctrl pcd_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_port_in(first_port_in), .first_port_out(first_port_out),
    .first_port_oe(first_port_oe), .uart_tx_enable(uart_tx_enable), .uart_txd(uart_txd),
    .stop_recovery(stop_recovery));
`default_nettype wire

// file: logic/pcd_pad_drive.sv
// per-bit output and enable for a bidirectional port
`default_nettype none
`timescale 1ns/1ps
module pcd_pad_drive #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic [WIDTH-1:0] dir_input,
    input wire logic [WIDTH-1:0] data,
    input wire logic push_pull,
    // pins
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe
);
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // open-drain releases a one instead of driving it
            always_comb begin
                next_pin_out[i] = data[i];
                next_pin_oe[i] = !dir_input[i] && (push_pull || !data[i]);
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end
endmodule : pcd_pad_drive
`default_nettype wire

// file: logic/pcd_pkg.sv
// constants for the port configuration and direction block
`default_nettype none
package pcd_pkg;
    // apb geometry
    localparam int PCD_ADDR_W = 16;
    localparam int PCD_DATA_W = 32;
    localparam int PCD_IDX_W = 12;
    localparam int PCD_PORT_W = 8;
    localparam int PCD_P3_OUT_W = 4;
    // register indices; byte address is four times the index
    localparam logic [11:0] PCD_IDX_FIRST_PORT_DATA = 12'h000;
    localparam logic [11:0] PCD_IDX_SECOND_PORT_DATA = 12'h002;
    localparam logic [11:0] PCD_IDX_THIRD_PORT_DATA = 12'h003;
    localparam logic [11:0] PCD_IDX_SECOND_PORT_DIRECTION = 12'h0f6;
    localparam logic [11:0] PCD_IDX_THIRD_PORT_MODE = 12'h0f7;
    localparam logic [11:0] PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION = 12'h0f8;
    localparam logic [11:0] PCD_IDX_PORT_OUTPUT_CONFIGURATION = 12'hf00;
    // field positions
    localparam int PCD_PORT_OUTPUT_CONFIGURATION_DRIVE_BIT = 2;
    localparam int PCD_PORT_OUTPUT_CONFIGURATION_CMP_OUT_BIT = 0;
    localparam int PCD_NIB_UPPER_BIT = 6;
    localparam int PCD_NIB_LOWER_BIT = 0;
    localparam int PCD_P3M_P2_PUSH_BIT = 0;
    localparam int PCD_P3M_ANALOG_BIT = 1;
    localparam int PCD_P3M_IR_BIT = 2;
    localparam int PCD_P3_LSB = 4;
    localparam int PCD_SHARED_A_BIT = 0;
    localparam int PCD_SHARED_B_BIT = 3;
    localparam int PCD_TOP_PIN = 7;
    // reset values
    localparam logic PCD_PORT_OUTPUT_CONFIGURATION_DRIVE_RST = 1'h1;
    localparam logic PCD_PORT_OUTPUT_CONFIGURATION_CMP_OUT_RST = 1'h0;
    localparam logic PCD_NIB_RST = 1'h1;
    localparam logic [7:0] PCD_P2_DIR_RST = 8'hff;
    localparam logic [2:0] PCD_P3M_RST = 3'h0;
    localparam logic [7:0] PCD_DATA_RST = 8'h00;
    localparam logic [3:0] PCD_P3_DATA_RST = 4'h0;
    // fixed read values of write-only and reserved bits
    localparam logic [7:0] PCD_PORT_OUTPUT_CONFIGURATION_READ = 8'hff;
    localparam logic [7:0] PCD_NIB_READ = 8'hff;
    localparam logic [7:0] PCD_P3M_READ = 8'hff;
endpackage : pcd_pkg
`default_nettype wire

// file: logic/pcd_port_ctrl.sv
// register file and pin control for the first, second and third ports
//
// Chosen here: register access over APB.
`default_nettype none
`timescale 1ns/1ps
module pcd_port_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [pcd_pkg::PCD_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcd_pkg::PCD_DATA_W-1:0] pwdata,
    output logic [pcd_pkg::PCD_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // first port pins
    input wire logic [pcd_pkg::PCD_PORT_W-1:0] first_port_in,
    output logic [pcd_pkg::PCD_PORT_W-1:0] first_port_out,
    output logic [pcd_pkg::PCD_PORT_W-1:0] first_port_oe,
    // second port pins
    input wire logic [pcd_pkg::PCD_PORT_W-1:0] second_port_in,
    output logic [pcd_pkg::PCD_PORT_W-1:0] second_port_out,
    output logic [pcd_pkg::PCD_PORT_W-1:0] second_port_oe,
    // third port output pins, bit 0 is shared pin a, bit 3 shared pin b
    output logic [pcd_pkg::PCD_P3_OUT_W-1:0] third_port_out,
    // uart transmitter
    input wire logic uart_tx_enable,
    input wire logic uart_txd,
    // analog results
    input wire logic comparator_1_result,
    input wire logic comparator_2_result,
    input wire logic ir_amp_result,
    // power management
    input wire logic stop_recovery
);
    import pcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic drive_push_pull;
    logic cmp_out_enable;
    logic nib_upper_input;
    logic nib_lower_input;
    logic [7:0] second_port_direction;
    logic [2:0] third_port_mode;
    logic [7:0] first_port_data;
    logic [7:0] second_port_data;
    logic [3:0] third_port_data;
    logic next_drive_push_pull;
    logic next_cmp_out_enable;
    logic next_nib_upper_input;
    logic next_nib_lower_input;
    logic [7:0] next_second_port_direction;
    logic [2:0] next_third_port_mode;
    logic [7:0] next_first_port_data;
    logic [7:0] next_second_port_data;
    logic [3:0] next_third_port_data;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic [PCD_IDX_W-1:0] reg_index;
    logic addr_ok;
    logic hit_p0;
    logic hit_p2;
    logic hit_p3;
    logic hit_p2dir;
    logic hit_p3m;
    logic hit_nib;
    logic hit_port_output_configuration;
    logic mapped;
    logic setup_phase;
    logic wr_commit;
    logic [7:0] wbyte;
    logic [7:0] read_byte;
    logic [PCD_DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] first_port_level;
    logic [7:0] second_port_level;

    assign reg_index = paddr[PCD_IDX_W+1:2];
    // upper address bits and byte offset must be clear
    assign addr_ok = (paddr[PCD_ADDR_W-1:PCD_IDX_W+2] == '0) && (paddr[1:0] == 2'h0);
    assign hit_p0 = addr_ok && (reg_index == PCD_IDX_FIRST_PORT_DATA);
    assign hit_p2 = addr_ok && (reg_index == PCD_IDX_SECOND_PORT_DATA);
    assign hit_p3 = addr_ok && (reg_index == PCD_IDX_THIRD_PORT_DATA);
    assign hit_p2dir = addr_ok && (reg_index == PCD_IDX_SECOND_PORT_DIRECTION);
    assign hit_p3m = addr_ok && (reg_index == PCD_IDX_THIRD_PORT_MODE);
    assign hit_nib = addr_ok && (reg_index == PCD_IDX_FIRST_PORT_NIBBLE_DIRECTION);
    assign hit_port_output_configuration = addr_ok && (reg_index == PCD_IDX_PORT_OUTPUT_CONFIGURATION);
    assign mapped = hit_p0 || hit_p2 || hit_p3 || hit_p2dir || hit_p3m || hit_nib || hit_port_output_configuration;
    assign setup_phase = psel && !penable;
    // no wait state: prdata and pready are registered in the setup cycle and come straight from flip-flops
    assign wr_commit = psel && penable && pready && pwrite && mapped;
    assign wbyte = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    pcd_sync #(
        .WIDTH(PCD_PORT_W)
    ) u_sync_first (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(first_port_in),
        .sync_out(first_port_level)
    );

    pcd_sync #(
        .WIDTH(PCD_PORT_W)
    ) u_sync_second (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(second_port_in),
        .sync_out(second_port_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        read_byte = 8'h00;
        if (hit_p0) begin
            read_byte = first_port_level;
        end else if (hit_p2) begin
            read_byte = second_port_level;
        end else if (hit_p3) begin
            read_byte = {third_port_data, 4'h0};
        end else if (hit_p2dir) begin
            read_byte = second_port_direction;
        end else if (hit_p3m) begin
            read_byte = PCD_P3M_READ;
        end else if (hit_nib) begin
            read_byte = PCD_NIB_READ;
        end else if (hit_port_output_configuration) begin
            read_byte = PCD_PORT_OUTPUT_CONFIGURATION_READ;
        end
    end

    always_comb begin
        next_pready = setup_phase;
        next_pslverr = setup_phase && !mapped;
        next_prdata = prdata;
        if (setup_phase) begin
            next_prdata = {24'h00_0000, read_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_comb begin
        next_drive_push_pull = drive_push_pull;
        next_cmp_out_enable = cmp_out_enable;
        next_nib_upper_input = nib_upper_input;
        next_nib_lower_input = nib_lower_input;
        next_second_port_direction = second_port_direction;
        next_third_port_mode = third_port_mode;
        next_first_port_data = first_port_data;
        next_second_port_data = second_port_data;
        next_third_port_data = third_port_data;
        // reserved bits have no storage, so writes to them vanish
        if (wr_commit && hit_port_output_configuration) begin
            next_drive_push_pull = wbyte[PCD_PORT_OUTPUT_CONFIGURATION_DRIVE_BIT];
            next_cmp_out_enable = wbyte[PCD_PORT_OUTPUT_CONFIGURATION_CMP_OUT_BIT];
        end
        if (wr_commit && hit_nib) begin
            next_nib_upper_input = wbyte[PCD_NIB_UPPER_BIT];
            next_nib_lower_input = wbyte[PCD_NIB_LOWER_BIT];
        end
        // stop recovery returns only the first port to inputs
        if (stop_recovery) begin
            next_nib_upper_input = PCD_NIB_RST;
            next_nib_lower_input = PCD_NIB_RST;
        end
        if (wr_commit && hit_p2dir) begin
            next_second_port_direction = wbyte;
        end
        if (wr_commit && hit_p3m) begin
            next_third_port_mode = wbyte[2:0];
        end
        if (wr_commit && hit_p0) begin
            next_first_port_data = wbyte;
        end
        if (wr_commit && hit_p2) begin
            next_second_port_data = wbyte;
        end
        if (wr_commit && hit_p3) begin
            next_third_port_data = wbyte[7:PCD_P3_LSB];
        end
    end

    // stop recovery never touches these: only presetn clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_push_pull <= PCD_PORT_OUTPUT_CONFIGURATION_DRIVE_RST;
            cmp_out_enable <= PCD_PORT_OUTPUT_CONFIGURATION_CMP_OUT_RST;
            second_port_direction <= PCD_P2_DIR_RST;
            third_port_mode <= PCD_P3M_RST;
        end else begin
            drive_push_pull <= next_drive_push_pull;
            cmp_out_enable <= next_cmp_out_enable;
            second_port_direction <= next_second_port_direction;
            third_port_mode <= next_third_port_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nib_upper_input <= PCD_NIB_RST;
            nib_lower_input <= PCD_NIB_RST;
            first_port_data <= PCD_DATA_RST;
            second_port_data <= PCD_DATA_RST;
            third_port_data <= PCD_P3_DATA_RST;
        end else begin
            nib_upper_input <= next_nib_upper_input;
            nib_lower_input <= next_nib_lower_input;
            first_port_data <= next_first_port_data;
            second_port_data <= next_second_port_data;
            third_port_data <= next_third_port_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // first port drive
    logic [7:0] first_dir_input;
    logic [7:0] first_drive_data;

    always_comb begin
        first_dir_input = {{4{nib_upper_input}}, {4{nib_lower_input}}};
        first_drive_data = first_port_data;
        // transmitter wins the top pin; direction still gates it
        if (uart_tx_enable) begin
            first_drive_data[PCD_TOP_PIN] = uart_txd;
        end
    end

    pcd_pad_drive #(
        .WIDTH(PCD_PORT_W)
    ) u_drive_first (
        .pclk(pclk),
        .presetn(presetn),
        .dir_input(first_dir_input),
        .data(first_drive_data),
        .push_pull(drive_push_pull),
        .pin_out(first_port_out),
        .pin_oe(first_port_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // second port drive
    pcd_pad_drive #(
        .WIDTH(PCD_PORT_W)
    ) u_drive_second (
        .pclk(pclk),
        .presetn(presetn),
        .dir_input(second_port_direction),
        .data(second_port_data),
        .push_pull(third_port_mode[PCD_P3M_P2_PUSH_BIT]),
        .pin_out(second_port_out),
        .pin_oe(second_port_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // third port shared outputs
    logic [3:0] next_third_port_out;
    logic cmp1_or_ir;

    // amplifier replaces comparator 1 only while the third port mode IR bit is set
    assign cmp1_or_ir = third_port_mode[PCD_P3M_IR_BIT] ? ir_amp_result : comparator_1_result;

    always_comb begin
        next_third_port_out = third_port_data;
        if (cmp_out_enable) begin
            next_third_port_out[PCD_SHARED_A_BIT] = cmp1_or_ir;
            next_third_port_out[PCD_SHARED_B_BIT] = comparator_2_result;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            third_port_out <= PCD_P3_DATA_RST;
        end else begin
            third_port_out <= next_third_port_out;
        end
    end
endmodule : pcd_port_ctrl
`default_nettype wire

// file: logic/pcd_sync.sv
// two flip-flop synchroniser for the pin inputs
`default_nettype none
`timescale 1ns/1ps
module pcd_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : pcd_sync
`default_nettype wire
